// ---- verilog/page_attribute_type_lookup.sv ----
// page attribute table register with memory type lookup and bus slave
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
module page_attribute_type_lookup (
   input  wire logic                        i_mclk,
   input  wire logic                        i_rst_n,
   input  wire logic                        i_hsel,
   input  wire logic [31:0]                 i_haddr,
   input  wire logic [1:0]                  i_htrans,
   input  wire logic                        i_hwrite,
   input  wire logic [2:0]                  i_hsize,
   input  wire logic [31:0]                 i_hwdata,
   input  wire logic                        i_hready,
   output logic      [31:0]                 o_hrdata,
   output logic                             o_hreadyout,
   output logic                             o_hresp,
   input  wire attr_table_pkg::walk_req_t   i_walk,
   output attr_table_pkg::lookup_rsp_t      o_rsp,
   output logic                             o_fault,
   output logic      [31:0]                 o_feature_d
);

   typedef struct packed {
      logic [63:0]                           table_v;
      logic [31:0]                           stage_lo;
      logic [31:0]                           feat_fn;
      logic [31:0]                           feat_res;
      logic                                  fault_sticky;
      logic                                  cause_rsvd;
      logic                                  cause_code;
      logic                                  fault_pulse;
      logic                                  dp_write;
      logic [7:0]                            dp_addr;
      logic [31:0]                           rdata;
      logic                                  rsp_valid;
      attr_table_pkg::mem_type_t             rsp_type;
      logic                                  rsp_next_level;
      logic [attr_table_pkg::PHYS_W-1:0]     rsp_addr;
   } state_t;

   state_t                    state_ff;
   state_t                    nxt_state;
   logic                      addr_phase;
   logic                      commit_hi;
   logic [1:0]                commit_chk;
   logic [2:0]                slot_idx;
   logic [31:0]               status_word;
   attr_table_pkg::policy_t   rsp_policy;

   assign addr_phase = i_hsel && i_htrans[1] && i_hready;
   assign commit_hi  = state_ff.dp_write && (state_ff.dp_addr == attr_table_pkg::OFS_TABLE_HI);
   // high word write commits the staged low word with it
   assign commit_chk = attr_table_pkg::check_table({i_hwdata, state_ff.stage_lo});

   assign status_word = {29'h0000_0000,
                         state_ff.cause_code,
                         state_ff.cause_rsvd,
                         state_ff.fault_sticky};

   // slot index from the entry bits of the level in use
   always_comb begin
      case (i_walk.level)
         attr_table_pkg::LEVEL_SMALL_PAGE: begin
            slot_idx = {i_walk.entry[attr_table_pkg::IDX_BIT_SMALL],
                        i_walk.entry[attr_table_pkg::CD_BIT],
                        i_walk.entry[attr_table_pkg::WT_BIT]};
         end
         attr_table_pkg::LEVEL_LARGE_PAGE: begin
            slot_idx = {i_walk.entry[attr_table_pkg::IDX_BIT_LARGE],
                        i_walk.entry[attr_table_pkg::CD_BIT],
                        i_walk.entry[attr_table_pkg::WT_BIT]};
         end
         default: begin
            slot_idx = {1'b0,
                        i_walk.entry[attr_table_pkg::CD_BIT],
                        i_walk.entry[attr_table_pkg::WT_BIT]};
         end
      endcase
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_state.fault_pulse = 1'b0;
      nxt_state.dp_write = 1'b0;

      // address phase: capture write target, prepare read data
      if (addr_phase) begin
         nxt_state.dp_write = i_hwrite;
         nxt_state.dp_addr = i_haddr[7:0];
         if (!i_hwrite) begin
            case (i_haddr[7:0])
               attr_table_pkg::OFS_TABLE_LO: nxt_state.rdata = state_ff.table_v[31:0];
               attr_table_pkg::OFS_TABLE_HI: nxt_state.rdata = state_ff.table_v[63:32];
               attr_table_pkg::OFS_STATUS:   nxt_state.rdata = status_word;
               attr_table_pkg::OFS_FEAT_FN:  nxt_state.rdata = state_ff.feat_fn;
               attr_table_pkg::OFS_FEAT_RES: nxt_state.rdata = state_ff.feat_res;
               default:                      nxt_state.rdata = 32'h0000_0000;
            endcase
         end
      end

      // data phase of a write
      if (state_ff.dp_write) begin
         case (state_ff.dp_addr)
            attr_table_pkg::OFS_TABLE_LO: begin
               nxt_state.stage_lo = i_hwdata;
            end
            attr_table_pkg::OFS_TABLE_HI: begin
               if (commit_chk != 2'h0) begin
                  nxt_state.fault_pulse = 1'b1;
                  nxt_state.fault_sticky = 1'b1;
                  nxt_state.cause_rsvd = commit_chk[0];
                  nxt_state.cause_code = commit_chk[1];
               end else begin
                  nxt_state.table_v = {i_hwdata, state_ff.stage_lo};
               end
            end
            attr_table_pkg::OFS_STATUS: begin
               // write one to clear the sticky fault and its causes
               if (i_hwdata[attr_table_pkg::STAT_FAULT_POS]) begin
                  nxt_state.fault_sticky = 1'b0;
               end
               if (i_hwdata[attr_table_pkg::STAT_RSVD_POS]) begin
                  nxt_state.cause_rsvd = 1'b0;
               end
               if (i_hwdata[attr_table_pkg::STAT_CODE_POS]) begin
                  nxt_state.cause_code = 1'b0;
               end
            end
            attr_table_pkg::OFS_FEAT_FN: begin
               nxt_state.feat_fn = i_hwdata;
            end
            default: begin
               nxt_state.feat_fn = state_ff.feat_fn;
            end
         endcase
      end

      // support bit for both identification functions
      if (nxt_state.feat_fn == attr_table_pkg::FN_BASIC
          || nxt_state.feat_fn == attr_table_pkg::FN_EXT) begin
         nxt_state.feat_res = attr_table_pkg::FEAT_RESULT;
      end else begin
         nxt_state.feat_res = 32'h0000_0000;
      end

      // lookup has no enable; every valid walk is typed
      nxt_state.rsp_valid = i_walk.valid;
      if (i_walk.valid) begin
         nxt_state.rsp_type = attr_table_pkg::mem_type_t'(
            state_ff.table_v[{slot_idx, 3'h0} +: attr_table_pkg::SLOT_W]);
         nxt_state.rsp_next_level = (i_walk.level == attr_table_pkg::LEVEL_UPPER);
         nxt_state.rsp_addr = i_walk.phys_addr;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         state_ff <= '0;
         state_ff.table_v <= attr_table_pkg::TABLE_RESET;
         state_ff.feat_fn <= attr_table_pkg::FEAT_FN_RST;
         state_ff.rsp_type <= attr_table_pkg::TYPE_UNCACHEABLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   type_policy_decode u_policy (
      .i_mclk   (i_mclk),
      .i_rst_n  (i_rst_n),
      .i_type   (nxt_state.rsp_type),
      .o_policy (rsp_policy)
   );

   assign o_hrdata    = state_ff.rdata;
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;
   assign o_fault     = state_ff.fault_pulse;
   assign o_feature_d = state_ff.feat_res;

   always_comb begin
      o_rsp.valid      = state_ff.rsp_valid;
      o_rsp.mem_type   = state_ff.rsp_type;
      o_rsp.next_level = state_ff.rsp_next_level;
      o_rsp.phys_addr  = state_ff.rsp_addr;
      o_rsp.policy     = rsp_policy;
   end

   reset_default_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> state_ff.table_v == attr_table_pkg::TABLE_RESET)
      else $error("table not at default after reset");

   reserved_zero_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (state_ff.table_v & attr_table_pkg::RSVD_MASK) == 64'h0000_0000_0000_0000)
      else $error("reserved table bit is set");

   rsvd_write_fault_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      commit_hi && |(i_hwdata & attr_table_pkg::RSVD_MASK[63:32]) |=>
         o_fault && state_ff.cause_rsvd && $stable(state_ff.table_v))
      else $error("reserved bit write did not fault or changed table");

   bad_code_fault_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      commit_hi && (i_hwdata[2:1] == 2'h1) |=>
         o_fault ##0 state_ff.cause_code ##0 $stable(state_ff.table_v))
      else $error("unsupported code write did not fault");

   good_write_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      commit_hi && commit_chk == 2'h0 |=>
         !o_fault && state_ff.table_v == {$past(i_hwdata), $past(state_ff.stage_lo)})
      else $error("valid table write not stored");

   large_slot_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_walk.valid && i_walk.level == attr_table_pkg::LEVEL_LARGE_PAGE
      && i_walk.entry[12] && !i_walk.entry[4] && !i_walk.entry[3] |=>
         o_rsp.mem_type == $past(state_ff.table_v[34:32]))
      else $error("large page did not select slot 4");

   upper_slot_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_walk.valid && i_walk.level == attr_table_pkg::LEVEL_UPPER
      && i_walk.entry[12] && i_walk.entry[7] && i_walk.entry[4] && i_walk.entry[3] |=>
         o_rsp.mem_type == $past(state_ff.table_v[26:24]) && o_rsp.next_level)
      else $error("upper level did not select slot 3");

   always_active_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_walk.valid |=> o_rsp.valid && o_rsp.phys_addr == $past(i_walk.phys_addr))
      else $error("lookup result missing one cycle after request");

   feature_bit_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      (state_ff.feat_fn == attr_table_pkg::FN_EXT
       || state_ff.feat_fn == attr_table_pkg::FN_BASIC) |-> o_feature_d[16])
      else $error("feature support bit not reported");

   // bus, status, lookup and feature checks
   bus_okay_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      o_hreadyout && !o_hresp)
      else $error("bus not ready or not okay");

   lo_staged_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      state_ff.dp_write && state_ff.dp_addr == attr_table_pkg::OFS_TABLE_LO
      |=> $stable(state_ff.table_v))
      else $error("low word write changed table");

   lo_read_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      addr_phase && !i_hwrite && i_haddr[7:0] == attr_table_pkg::OFS_TABLE_LO
      |=> o_hrdata == $past(state_ff.table_v[31:0]))
      else $error("low word read wrong");

   hi_read_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      addr_phase && !i_hwrite && i_haddr[7:0] == attr_table_pkg::OFS_TABLE_HI
      |=> o_hrdata == $past(state_ff.table_v[63:32]))
      else $error("high word read wrong");

   status_read_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      addr_phase && !i_hwrite && i_haddr[7:0] == attr_table_pkg::OFS_STATUS
      |=> o_hrdata == $past(status_word))
      else $error("status read wrong");

   feat_read_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      addr_phase && !i_hwrite && i_haddr[7:0] == attr_table_pkg::OFS_FEAT_RES
      |=> o_hrdata == $past(o_feature_d))
      else $error("feature result read wrong");

   fault_sticky_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      o_fault |-> state_ff.fault_sticky && (state_ff.cause_rsvd || state_ff.cause_code))
      else $error("fault not recorded in status");

   rsvd_cause_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      commit_hi && commit_chk == 2'h1
      |=> o_fault && state_ff.cause_rsvd && !state_ff.cause_code)
      else $error("reserved cause not recorded");

   status_clear_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      state_ff.dp_write && state_ff.dp_addr == attr_table_pkg::OFS_STATUS
      && i_hwdata[attr_table_pkg::STAT_FAULT_POS] |=> !state_ff.fault_sticky)
      else $error("sticky fault not cleared");

   small_slot_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_walk.valid && i_walk.level == attr_table_pkg::LEVEL_SMALL_PAGE
      && i_walk.entry[7] && !i_walk.entry[4] && i_walk.entry[3] |=>
         o_rsp.mem_type == $past(state_ff.table_v[42:40]))
      else $error("small page did not select slot 5");

   cd_slot_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_walk.valid && i_walk.level == attr_table_pkg::LEVEL_SMALL_PAGE
      && !i_walk.entry[7] && i_walk.entry[4] && !i_walk.entry[3] |=>
         o_rsp.mem_type == $past(state_ff.table_v[18:16]))
      else $error("cache disable did not select slot 2");

   type_legal_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      o_rsp.valid |-> o_rsp.mem_type != 3'h2 && o_rsp.mem_type != 3'h3)
      else $error("unsupported type issued");

   upper_level_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_walk.valid && i_walk.level != attr_table_pkg::LEVEL_UPPER |=> !o_rsp.next_level)
      else $error("lower level flagged as next level");

   rsp_hold_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      !i_walk.valid |=> !o_rsp.valid && $stable(o_rsp.phys_addr) && $stable(o_rsp.mem_type))
      else $error("lookup result changed without request");

   feature_zero_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      state_ff.feat_fn != attr_table_pkg::FN_BASIC
      && state_ff.feat_fn != attr_table_pkg::FN_EXT |-> o_feature_d == 32'h0000_0000)
      else $error("feature bit reported for other function");

endmodule

// ---- verilog/attr_table_pkg.sv ----
// constants and carrier types for the page attribute type lookup
package attr_table_pkg;

   localparam int unsigned TABLE_W     = 64;
   localparam int unsigned SLOTS       = 8;
   localparam int unsigned SLOT_W      = 3;
   localparam int unsigned SLOT_STRIDE = 8;
   localparam int unsigned PHYS_W      = 52;

   // register byte offsets
   localparam logic [7:0] OFS_TABLE_LO = 8'h00;
   localparam logic [7:0] OFS_TABLE_HI = 8'h04;
   localparam logic [7:0] OFS_STATUS   = 8'h08;
   localparam logic [7:0] OFS_FEAT_FN  = 8'h0C;
   localparam logic [7:0] OFS_FEAT_RES = 8'h10;

   // status fields
   localparam int unsigned STAT_FAULT_POS = 0;
   localparam int unsigned STAT_RSVD_POS  = 1;
   localparam int unsigned STAT_CODE_POS  = 2;

   localparam logic [63:0] TABLE_RESET = 64'h0007_0406_0007_0406;
   localparam logic [63:0] RSVD_MASK   = 64'hF8F8_F8F8_F8F8_F8F8;
   localparam logic [31:0] FEAT_FN_RST = 32'h0000_0000;

   // feature identification
   localparam logic [31:0] FN_BASIC    = 32'h0000_0001;
   localparam logic [31:0] FN_EXT      = 32'h8000_0001;
   localparam logic [31:0] FEAT_RESULT = 32'h0001_0000;

   // entry bit positions
   localparam int unsigned IDX_BIT_SMALL = 7;
   localparam int unsigned IDX_BIT_LARGE = 12;
   localparam int unsigned CD_BIT        = 4;
   localparam int unsigned WT_BIT        = 3;

   typedef enum logic [2:0] {
      TYPE_UNCACHEABLE      = 3'h0,
      TYPE_WRITE_COMBINING  = 3'h1,
      TYPE_WRITE_THROUGH    = 3'h4,
      TYPE_WRITE_PROTECT    = 3'h5,
      TYPE_WRITE_BACK       = 3'h6,
      TYPE_WEAK_UNCACHEABLE = 3'h7
   } mem_type_t;

   typedef enum logic [1:0] {
      LEVEL_SMALL_PAGE = 2'h0,
      LEVEL_LARGE_PAGE = 2'h1,
      LEVEL_UPPER      = 2'h3
   } entry_level_t;

   typedef struct packed {
      logic              valid;
      entry_level_t      level;
      logic [12:0]       entry;
      logic [PHYS_W-1:0] phys_addr;
   } walk_req_t;

   typedef struct packed {
      logic cacheable;
      logic combine_ok;
      logic spec_read_ok;
      logic read_alloc_shared;
      logic read_alloc_excl_ok;
      logic write_alloc_modified;
      logic write_to_memory;
      logic write_hit_invalidate;
      logic range_wc_override;
   } policy_t;

   typedef struct packed {
      logic              valid;
      mem_type_t         mem_type;
      logic              next_level;
      logic [PHYS_W-1:0] phys_addr;
      policy_t           policy;
   } lookup_rsp_t;

   // returns {unsupported code seen, reserved bit set}
   function automatic logic [1:0] check_table(input logic [63:0] v);
      logic       bad;
      logic [2:0] code;
      bad = 1'b0;
      code = 3'h0;
      for (int i = 0; i < SLOTS; i++) begin
         code = v[i*SLOT_STRIDE +: SLOT_W];
         if (code == 3'h2 || code == 3'h3) begin
            bad = 1'b1;
         end
      end
      return {bad, |(v & RSVD_MASK)};
   endfunction

endpackage

// ---- verilog/type_policy_decode.sv ----
// registered decode of a memory type code into access policy
`timescale 1ns/100ps
module type_policy_decode (
   input  wire logic                      i_mclk,
   input  wire logic                      i_rst_n,
   input  wire attr_table_pkg::mem_type_t i_type,
   output attr_table_pkg::policy_t        o_policy
);

   typedef struct packed {
      attr_table_pkg::policy_t policy;
   } dec_state_t;

   dec_state_t state_ff;
   dec_state_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      nxt_state.policy = '0;
      case (i_type)
         attr_table_pkg::TYPE_WRITE_COMBINING: begin
            nxt_state.policy.combine_ok = 1'b1;
            nxt_state.policy.spec_read_ok = 1'b1;
            nxt_state.policy.write_to_memory = 1'b1;
         end
         attr_table_pkg::TYPE_WRITE_THROUGH: begin
            nxt_state.policy.cacheable = 1'b1;
            nxt_state.policy.read_alloc_shared = 1'b1;
            nxt_state.policy.write_to_memory = 1'b1;
         end
         attr_table_pkg::TYPE_WRITE_PROTECT: begin
            nxt_state.policy.cacheable = 1'b1;
            nxt_state.policy.read_alloc_shared = 1'b1;
            nxt_state.policy.write_to_memory = 1'b1;
            nxt_state.policy.write_hit_invalidate = 1'b1;
         end
         attr_table_pkg::TYPE_WRITE_BACK: begin
            nxt_state.policy.cacheable = 1'b1;
            nxt_state.policy.read_alloc_shared = 1'b1;
            nxt_state.policy.read_alloc_excl_ok = 1'b1;
            nxt_state.policy.write_alloc_modified = 1'b1;
         end
         attr_table_pkg::TYPE_WEAK_UNCACHEABLE: begin
            nxt_state.policy.write_to_memory = 1'b1;
            nxt_state.policy.range_wc_override = 1'b1;
         end
         default: begin
            nxt_state.policy.write_to_memory = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign o_policy = state_ff.policy;

   uc_policy_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_type == attr_table_pkg::TYPE_UNCACHEABLE |=>
         !o_policy.cacheable && !o_policy.combine_ok && !o_policy.spec_read_ok)
      else $error("uncacheable type allowed caching, combining or speculation");

   weak_uc_policy_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_type == attr_table_pkg::TYPE_WEAK_UNCACHEABLE |=>
         !o_policy.cacheable && !o_policy.combine_ok && o_policy.range_wc_override)
      else $error("weak uncacheable type not like uncacheable");

   wt_policy_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_type == attr_table_pkg::TYPE_WRITE_THROUGH |=>
         o_policy.read_alloc_shared && !o_policy.read_alloc_excl_ok
         && !o_policy.write_alloc_modified && o_policy.write_to_memory)
      else $error("write through policy wrong");

   wp_policy_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_type == attr_table_pkg::TYPE_WRITE_PROTECT |=>
         o_policy.write_hit_invalidate && o_policy.write_to_memory
         && !o_policy.write_alloc_modified)
      else $error("write protect policy wrong");

   wb_policy_a: assert property (
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_type == attr_table_pkg::TYPE_WRITE_BACK |=>
         o_policy.write_alloc_modified && o_policy.read_alloc_excl_ok
         && !o_policy.write_to_memory)
      else $error("write back policy wrong");

endmodule

// ---- testbench/walk_source.sv ----
// translation side model issuing one lookup request at a time
`timescale 1ns/100ps
module walk_source (
   input  wire logic                  i_mclk,
   output attr_table_pkg::walk_req_t o_walk
);
   initial o_walk = '0;

   task automatic send(input attr_table_pkg::entry_level_t lvl, input logic [2:0] idx,
                       input logic [attr_table_pkg::PHYS_W-1:0] pa);
      attr_table_pkg::walk_req_t r;
      r = '0;
      r.valid = 1'b1;
      r.level = lvl;
      r.phys_addr = pa;
      r.entry[attr_table_pkg::CD_BIT] = idx[1];
      r.entry[attr_table_pkg::WT_BIT] = idx[0];
      // for a small or large page the unused position carries the opposite value to expose a wrong pick
      r.entry[attr_table_pkg::IDX_BIT_SMALL] = idx[2] ^ (lvl == attr_table_pkg::LEVEL_LARGE_PAGE);
      r.entry[attr_table_pkg::IDX_BIT_LARGE] = idx[2] ^ (lvl == attr_table_pkg::LEVEL_SMALL_PAGE);
      @(posedge i_mclk);
      o_walk <= r;
      @(posedge i_mclk);
      // released fields no longer show the request
      r.valid = 1'b0;
      r.entry = ~r.entry;
      r.phys_addr = ~r.phys_addr;
      o_walk <= r;
   endtask
endmodule

// ---- testbench/page_attribute_type_lookup_tb.sv ----
// self-checking bench for the page attribute type lookup
`timescale 1ns/100ps
module page_attribute_type_lookup_tb;
   logic                        mclk;
   logic                        rst_n;
   logic                        hsel;
   logic [31:0]                 haddr;
   logic [1:0]                  htrans;
   logic                        hwrite;
   logic [31:0]                 hwdata;
   logic [31:0]                 hrdata;
   logic                        hreadyout;
   logic                        hresp;
   attr_table_pkg::walk_req_t   walk;
   attr_table_pkg::lookup_rsp_t rsp;
   logic                        fault;
   logic [31:0]                 feature_d;
   logic [63:0]                 tbl;
   int                          n_errors;
   int                          checks;

   initial mclk = 1'b0;
   always #4 mclk = ~mclk;

   page_attribute_type_lookup DUT (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
      .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .i_walk(walk),
      .o_rsp(rsp), .o_fault(fault), .o_feature_d(feature_d)
   );
   walk_source src (.i_mclk(mclk), .o_walk(walk));

   task automatic summarize();
      $display("checks %0d, errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic wait_ready();
      int k;
      k = 0;
      @(posedge mclk);
      while (hreadyout !== 1'b1) begin
         k++;
         if (k > 16) begin
            n_errors++;
            $display("unexpected hready: expected 1, seen %b", hreadyout);
            summarize();
         end
         @(posedge mclk);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] ofs, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, ofs};
      hwrite <= w;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      chk("hresp", 64'h0, 64'(hresp));
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, ofs, d, x);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] ofs, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, ofs, 32'h0000_0000, x);
      chk(name, 64'(exp), 64'(x));
   endtask

   task automatic fault_cnt(input int exp);
      int n;
      n = 0;
      repeat (3) begin
         @(negedge mclk);
         if (fault === 1'b1) n++;
      end
      @(posedge mclk);
      chk("fault pulses", 64'(exp), 64'(n));
   endtask

   task automatic look(input attr_table_pkg::entry_level_t lvl, input logic [2:0] idx);
      logic        up;
      logic [2:0]  eff;
      logic [2:0]  t;
      logic [51:0] pa;
      up = (lvl == attr_table_pkg::LEVEL_UPPER);
      eff = up ? {1'b0, idx[1:0]} : idx;
      t = tbl[eff*8 +: 3];
      pa = {idx, 1'b0, 48'h1234_5678_9ABC};
      src.send(lvl, idx, pa);
      @(negedge mclk);
      chk("rsp valid", 64'h1, 64'(rsp.valid));
      chk("mem type", 64'(t), 64'(rsp.mem_type));
      chk("phys addr", 64'(pa), 64'(rsp.phys_addr));
      chk("next level", 64'(up), 64'(rsp.next_level));
      chk("policy", 64'({t inside {3'h4, 3'h5, 3'h6}, t == 3'h6, t == 3'h5, t == 3'h7}),
          64'({rsp.policy.cacheable, rsp.policy.write_alloc_modified,
               rsp.policy.write_hit_invalidate, rsp.policy.range_wc_override}));
      @(posedge mclk);
   endtask

   task automatic t_reset();
      rd_chk("table lo", attr_table_pkg::OFS_TABLE_LO, 32'h0007_0406);
      rd_chk("table hi", attr_table_pkg::OFS_TABLE_HI, 32'h0007_0406);
      for (int i = 0; i < 8; i++) begin
         look(attr_table_pkg::LEVEL_SMALL_PAGE, 3'(i));
      end
   endtask

   task automatic t_write();
      attr_table_pkg::entry_level_t lv[3] = '{attr_table_pkg::LEVEL_SMALL_PAGE,
         attr_table_pkg::LEVEL_LARGE_PAGE, attr_table_pkg::LEVEL_UPPER};
      tbl = 64'h0407_0605_0401_0006;
      wr(attr_table_pkg::OFS_TABLE_LO, tbl[31:0]);
      wr(attr_table_pkg::OFS_TABLE_HI, tbl[63:32]);
      fault_cnt(0);
      rd_chk("table lo", attr_table_pkg::OFS_TABLE_LO, tbl[31:0]);
      rd_chk("table hi", attr_table_pkg::OFS_TABLE_HI, tbl[63:32]);
      for (int l = 0; l < 3; l++) begin
         for (int i = 0; i < 8; i++) begin
            look(lv[l], 3'(i));
         end
      end
   endtask

   task automatic t_fault();
      logic [31:0] blo[4] = '{32'h0401_000E, 32'h0401_0006, 32'h0401_0006, 32'h0401_0003};
      logic [31:0] bhi[4] = '{32'h0407_0605, 32'h8407_0605, 32'h0207_0602, 32'h0407_0605};
      logic [31:0] st[4] = '{32'h0000_0003, 32'h0000_0003, 32'h0000_0005, 32'h0000_0005};
      for (int i = 0; i < 4; i++) begin
         wr(attr_table_pkg::OFS_TABLE_LO, blo[i]);
         wr(attr_table_pkg::OFS_TABLE_HI, bhi[i]);
         fault_cnt(1);
         rd_chk("table lo", attr_table_pkg::OFS_TABLE_LO, tbl[31:0]);
         rd_chk("table hi", attr_table_pkg::OFS_TABLE_HI, tbl[63:32]);
         rd_chk("status", attr_table_pkg::OFS_STATUS, st[i]);
         wr(attr_table_pkg::OFS_STATUS, 32'h0000_0007);
      end
      look(attr_table_pkg::LEVEL_SMALL_PAGE, 3'h7);
      wr(8'h40, 32'hFFFF_FFFF);
      rd_chk("unmapped", 8'h40, 32'h0000_0000);
      rd_chk("status", attr_table_pkg::OFS_STATUS, 32'h0000_0000);
   endtask

   task automatic t_feature();
      logic [31:0] fn[3] = '{32'h0000_0001, 32'h8000_0001, 32'h0000_0002};
      logic [31:0] e;
      for (int i = 0; i < 3; i++) begin
         e = (i < 2) ? 32'h0001_0000 : 32'h0000_0000;
         wr(attr_table_pkg::OFS_FEAT_FN, fn[i]);
         @(negedge mclk);
         chk("feature d", 64'(e), 64'(feature_d));
         @(posedge mclk);
         rd_chk("feature result", attr_table_pkg::OFS_FEAT_RES, e);
      end
   endtask

   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      n_errors = 0;
      checks = 0;
      tbl = 64'h0007_0406_0007_0406;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_write();
      t_fault();
      t_feature();
      summarize();
   end
endmodule
